// ==== src/ops_system_words.sv ====
// System control and status word area of the operator panel
//
// Operation
// [R1] All-ones blank word turns display off
// [R2] Zero blank word: on, idle timeout blanks
// [R3] Touch turns a blanked display back on
// [R4] Interrupt word sends low byte, never FFh
// [R5] Host avoids control codes in interrupt word
// [R6] Screen word: number bits 0-14, force 15
// [R7] Window control: display on, overlap lock
// [R8] Window number and X/Y position words
// [R9] Backlight-off bit dims only the backlight
// [R10] Buzzer bit drives internal and aux buzzer
// [R11] Hard-copy disable cancels and blocks printing
// [R12] Cancel finishes current image, keeps buffer
// [R13] Wake interrupt only on touch wake
// [R14] Each keyed entry toggles written bit
// [R15] Entry error set out-of-range, cleared otherwise
// [R16] Host never writes reserved words
// [R17] Control use of words suspends tag displays
// [R18] Bit writes to words 12,13,15 ignored; the code still sets tagSuspend on them
// [R19] Host writes reserved control bits zero
// [R20] Host ignores reserved status bits
// [R21] Special relay area 2032-2047, reserved undefined
// [R22] Seconds counter counts from power-up
// [R23] Each completed write applies once
`timescale 1ns/10ps
`default_nettype none
`include "ops_params.svh"

module ops_system_words
#(
  parameter int SEC_CYCLES = `OPS_SEC_CYCLES
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  input  wire ops_pkg::ops_hostreq_s hostReq,
  output logic                       rdValid,
  output logic [15:0]                rdData,
  output ops_pkg::ops_intr_s         intOut,
  input  wire logic                  touchEvent,
  input  wire logic [15:0]           standbySeconds,
  input  wire logic                  numberFormatSelect,
  input  wire logic                  entryStrobe,
  input  wire logic                  entryInRange,
  input  wire logic                  printDone,
  input  wire logic                  printImageEnd,
  input  wire logic [15:0]           relayStatus,
  input  wire logic [15:0]           scanDuration,
  input  wire logic [15:0]           scanCount,
  output logic                       displayOn,
  output logic                       backlightOn,
  output logic                       buzzerInternal,
  output logic                       buzzerAux,
  output logic                       vgaMode,
  output logic                       printRun,
  output logic                       printCancel,
  output logic                       screenChange,
  output logic [14:0]                screenNum,
  output logic                       screenForce,
  output logic                       windowShow,
  output logic                       windowOrderLock,
  output logic [15:0]                windowNumber,
  output logic [15:0]                windowPosX,
  output logic [15:0]                windowPosY,
  output logic                       tagSuspend
);
  import ops_pkg::*;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic [15:0] mergeBit(input logic [15:0] cur, input ops_hostreq_s r);
    logic [15:0] v;
    v = r.data;
    // A whole-word write outranks a bit write raised with it
    if (r.bitWr && !r.wr) begin
      v = cur;
      v[r.bitIdx] = r.bitVal;
    end
    return v;
  endfunction

  function automatic logic validScreen(input logic [14:0] n, input logic bcd);
    logic ok;
    ok = (n != 15'h0);
    if (bcd) begin
      ok = ok && (n[3:0] <= 4'h9) && (n[7:4] <= 4'h9) && (n[11:8] <= 4'h9) && (n[14:12] <= 3'h1);
    end else begin
      ok = ok && (n <= `OPS_SCR_MAX_BIN);
    end
    return ok;
  endfunction

  // ------------------------------------------------------------------
  // Write decode
  // ------------------------------------------------------------------
  logic        anyWr, blankWr, intWr, scrWr, ctlWr, scrOk, secTick;
  logic        valueWritten, entryError, prevStart, wakePend, touchWake, autoBlank;
  logic [15:0] control;
  logic [15:0] windowCtl;
  logic [15:0] seconds;
  logic [15:0] statusWord;
  ops_print_e  printState;
  logic [15:0] idleSeconds;

  assign anyWr   = hostReq.wr | hostReq.bitWr; // R23
  // Whole-word strobe only for the three command words
  assign blankWr = hostReq.wr && hostReq.addr == `OPS_ADDR_BLANK;   // R18
  assign intWr   = hostReq.wr && hostReq.addr == `OPS_ADDR_INTCODE; // R18
  assign scrWr   = hostReq.wr && hostReq.addr == `OPS_ADDR_SCREEN;  // R18
  assign ctlWr   = anyWr && hostReq.addr == `OPS_ADDR_CONTROL;
  assign scrOk   = validScreen(hostReq.data[14:0], numberFormatSelect); // R6

  // ------------------------------------------------------------------
  // Control word and its pins
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      control <= 16'h0;
    end else if (ctlWr) begin
      control <= mergeBit(control, hostReq) & `OPS_CTL_MASK; // R19
    end
  end

  // Backlight alone; display and touch are left untouched
  assign backlightOn    = ~control[`OPS_CTL_BACKLIGHT]; // R9
  assign buzzerInternal = control[`OPS_CTL_BUZZON] & ~control[`OPS_CTL_BUZZDIS]; // R10
  assign buzzerAux      = control[`OPS_CTL_BUZZON] & ~control[`OPS_CTL_AUXDIS];  // R10
  assign vgaMode        = control[`OPS_CTL_VGA];

  // ------------------------------------------------------------------
  // Display blanking
  // ------------------------------------------------------------------
  ops_second_tick #(
    .SEC_CYCLES (SEC_CYCLES)
  ) u_tick (
    .mclk    (mclk),
    .rst     (rst),
    .tick    (secTick),
    .seconds (seconds)
  );

  assign touchWake = touchEvent && !displayOn && !(blankWr && (hostReq.data == `OPS_BLANK_OFF || ~|hostReq.data)); // R13

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      displayOn   <= 1'b1;
      autoBlank   <= 1'b1;
      idleSeconds <= 16'h0;
    end else if (blankWr && hostReq.data == `OPS_BLANK_OFF) begin
      displayOn   <= 1'b0; // R1
      autoBlank   <= 1'b0;
    end else if (blankWr && hostReq.data == `OPS_BLANK_ON) begin
      displayOn   <= 1'b1; // R2
      autoBlank   <= 1'b1;
      idleSeconds <= 16'h0;
    end else if (touchEvent) begin
      displayOn   <= 1'b1; // R3
      idleSeconds <= 16'h0;
    end else if (autoBlank && displayOn && secTick && standbySeconds != 16'h0) begin
      // A zero standby time means the screen never blanks on idle
      if (idleSeconds + 16'h1 >= standbySeconds) begin
        displayOn <= 1'b0; // R2
      end
      idleSeconds <= idleSeconds + 16'h1;
    end
  end

  // ------------------------------------------------------------------
  // Interrupt codes to the host
  // ------------------------------------------------------------------
  // Host code wins the slot; a touch wake waits one cycle behind it
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      intOut   <= '0;
      wakePend <= 1'b0;
    end else if (intWr && hostReq.data[7:0] != `OPS_WAKE_CODE) begin
      intOut.valid <= 1'b1; // R4
      intOut.code  <= hostReq.data[7:0];
      wakePend     <= wakePend | (touchWake & control[`OPS_CTL_WAKEINT]);
    end else if (wakePend || (touchWake && control[`OPS_CTL_WAKEINT])) begin
      intOut.valid <= 1'b1; // R13
      intOut.code  <= `OPS_WAKE_CODE;
      wakePend     <= 1'b0;
    end else begin
      intOut.valid <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Screen and window words
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      screenNum    <= 15'h1;
      screenForce  <= 1'b0;
      screenChange <= 1'b0;
    end else begin
      screenChange <= scrWr && scrOk; // R6
      if (scrWr && scrOk) begin
        screenNum   <= hostReq.data[14:0];
        screenForce <= hostReq.data[`OPS_SCR_FORCE];
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      windowCtl    <= 16'h0;
      windowNumber <= 16'h0;
      windowPosX   <= 16'h0;
      windowPosY   <= 16'h0;
    end else if (anyWr) begin
      case (hostReq.addr)
        `OPS_ADDR_WINCTL: windowCtl    <= mergeBit(windowCtl, hostReq) & `OPS_WIN_MASK; // R7
        `OPS_ADDR_WINNUM: windowNumber <= mergeBit(windowNumber, hostReq); // R8
        `OPS_ADDR_WINX:   windowPosX   <= mergeBit(windowPosX, hostReq);   // R8
        `OPS_ADDR_WINY:   windowPosY   <= mergeBit(windowPosY, hostReq);   // R8
        default: ;
      endcase
    end
  end

  assign windowShow      = windowCtl[0]; // R7
  assign windowOrderLock = windowCtl[1]; // R7

  // Once claimed for control the tag displays stay off until reset
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tagSuspend <= 1'b0;
    end else if (anyWr && (hostReq.addr == `OPS_ADDR_TAGCTL || hostReq.addr == `OPS_ADDR_BLANK ||
                           hostReq.addr == `OPS_ADDR_INTCODE || hostReq.addr == `OPS_ADDR_SCREEN)) begin
      tagSuspend <= 1'b1; // R17
    end
  end

  // ------------------------------------------------------------------
  // Keyed entry status
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      valueWritten <= 1'b0;
    end else if (entryStrobe) begin
      valueWritten <= ~valueWritten; // R14
    end
  end

  // An out-of-range entry beats a screen change in the same cycle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      entryError <= 1'b0;
    end else if (entryStrobe && !entryInRange) begin
      entryError <= 1'b1; // R15
    end else if (entryStrobe || screenChange) begin
      entryError <= 1'b0; // R15
    end
  end

  // ------------------------------------------------------------------
  // Hard copy
  // ------------------------------------------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      printState <= PR_IDLE;
      prevStart  <= 1'b0;
    end else begin
      prevStart <= control[`OPS_CTL_PRINTSTART];
      case (printState)
        PR_IDLE: begin
          if (control[`OPS_CTL_PRINTSTART] && !prevStart && !control[`OPS_CTL_HCDIS]) begin
            printState <= PR_RUN; // R11
          end
        end
        PR_RUN: begin
          if (printDone) begin
            printState <= PR_IDLE;
          end else if (control[`OPS_CTL_HCDIS]) begin
            printState <= PR_DRAIN; // R11
          end
        end
        PR_DRAIN: begin
          if (printImageEnd) begin
            printState <= PR_IDLE; // R12
          end
        end
        default: printState <= PR_IDLE;
      endcase
    end
  end

  assign printRun    = printState == PR_RUN;
  // Engine finishes the image in hand and keeps its buffer
  assign printCancel = printState == PR_DRAIN; // R12

  // ------------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------------
  always_comb begin
    statusWord = 16'h0;
    statusWord[`OPS_ST_PRINTING] = printState != PR_IDLE; // R11
    statusWord[`OPS_ST_WRITTEN]  = valueWritten;
    statusWord[`OPS_ST_ENTRYERR] = entryError;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdValid <= 1'b0;
      rdData  <= 16'h0;
    end else begin
      rdValid <= hostReq.rd;
      if (hostReq.rd) begin
        case (hostReq.addr)
          `OPS_ADDR_STATUS:    rdData <= statusWord;
          `OPS_ADDR_CONTROL:   rdData <= control;
          `OPS_ADDR_SCREEN:    rdData <= {screenForce, screenNum};
          `OPS_ADDR_WINCTL:    rdData <= windowCtl;
          `OPS_ADDR_WINNUM:    rdData <= windowNumber;
          `OPS_ADDR_WINX:      rdData <= windowPosX;
          `OPS_ADDR_WINY:      rdData <= windowPosY;
          `OPS_ADDR_RELAY:     rdData <= (relayStatus & `OPS_RELAY_MASK) | `OPS_RELAY_ON; // R21
          `OPS_ADDR_BASESCR:   rdData <= {1'b0, screenNum};
          `OPS_ADDR_SECONDS:   rdData <= seconds; // R22
          `OPS_ADDR_SCANTIME:  rdData <= scanDuration;
          `OPS_ADDR_SCANCOUNT: rdData <= scanCount;
          default:             rdData <= 16'h0; // R21
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_cancel;
    printState == PR_RUN && control[`OPS_CTL_HCDIS] && !printDone;
  endsequence

  sequence s_drain_end;
    printState == PR_DRAIN && printImageEnd;
  endsequence

  a_blank_write: assert property (@(posedge mclk) disable iff (rst) // R1
    blankWr && hostReq.data == `OPS_BLANK_OFF |=> !displayOn) else $error("display not blanked");
  a_zero_on: assert property (@(posedge mclk) disable iff (rst) // R2
    blankWr && hostReq.data == `OPS_BLANK_ON |=> displayOn && autoBlank) else $error("display not on");
  a_touch_wake: assert property (@(posedge mclk) disable iff (rst) // R3
    touchWake |=> displayOn) else $error("touch did not wake display");
  a_int_code: assert property (@(posedge mclk) disable iff (rst) // R4
    intWr && hostReq.data[7:0] != `OPS_WAKE_CODE |=> intOut.valid && intOut.code == $past(hostReq.data[7:0]))
    else $error("interrupt code not sent");
  a_wake_only: assert property (@(posedge mclk) disable iff (rst) // R13
    intOut.valid && intOut.code == `OPS_WAKE_CODE |-> $past(wakePend) || $past(touchWake && control[`OPS_CTL_WAKEINT]))
    else $error("wake code without touch wake");
  a_bit_block: assert property (@(posedge mclk) disable iff (rst) // R18
    hostReq.bitWr && !hostReq.wr && hostReq.addr == `OPS_ADDR_SCREEN |=> !screenChange)
    else $error("bit write changed screen");
  a_print_cancel: assert property (@(posedge mclk) disable iff (rst) // R11
    s_cancel |=> printCancel && !printRun) else $error("print not cancelled");
  a_drain_stop: assert property (@(posedge mclk) disable iff (rst) // R12
    s_drain_end |=> printState == PR_IDLE && !printCancel) else $error("drain did not end at image end");
  a_entry_toggle: assert property (@(posedge mclk) disable iff (rst) // R14
    entryStrobe |=> valueWritten != $past(valueWritten)) else $error("written bit not toggled");
  a_entry_error: assert property (@(posedge mclk) disable iff (rst) // R15
    screenChange && !(entryStrobe && !entryInRange) |=> !entryError) else $error("error kept over screen change");

endmodule
`default_nettype wire

// ==== src/ops_params.svh ====
// Offsets, field positions, values and timing counts of the panel system words
`ifndef OPS_PARAMS_SVH
`define OPS_PARAMS_SVH

// ------------------------------------------------------------------
// Word addresses
// ------------------------------------------------------------------
`define OPS_ADDR_STATUS      11'h001
`define OPS_ADDR_RSV_A       11'h000
`define OPS_ADDR_RSV_B       11'h002
`define OPS_ADDR_TAGCTL      11'h003
`define OPS_ADDR_RSV_C       11'h009
`define OPS_ADDR_RSV_D       11'h00a
`define OPS_ADDR_CONTROL     11'h00b
`define OPS_ADDR_BLANK       11'h00c
`define OPS_ADDR_INTCODE     11'h00d
`define OPS_ADDR_RSV_E       11'h00e
`define OPS_ADDR_SCREEN      11'h00f
`define OPS_ADDR_WINCTL      11'h010
`define OPS_ADDR_WINNUM      11'h011
`define OPS_ADDR_WINX        11'h012
`define OPS_ADDR_WINY        11'h013
`define OPS_ADDR_RELAY       11'h7f0
`define OPS_ADDR_BASESCR     11'h7f1
`define OPS_ADDR_SECONDS     11'h7f4
`define OPS_ADDR_SCANTIME    11'h7f5
`define OPS_ADDR_SCANCOUNT   11'h7f7

// ------------------------------------------------------------------
// Field positions and masks
// ------------------------------------------------------------------
`define OPS_ST_PRINTING      4'd2
`define OPS_ST_WRITTEN       4'd3
`define OPS_ST_ENTRYERR      4'd8
`define OPS_CTL_BACKLIGHT    4'd0
`define OPS_CTL_BUZZON       4'd1
`define OPS_CTL_PRINTSTART   4'd2
`define OPS_CTL_BUZZDIS      4'd4
`define OPS_CTL_AUXDIS       4'd5
`define OPS_CTL_WAKEINT      4'd6
`define OPS_CTL_VGA          4'd8
`define OPS_CTL_HCDIS        4'd11
`define OPS_CTL_MASK         16'h0977
`define OPS_WIN_MASK         16'h0003
`define OPS_SCR_FORCE        4'd15
`define OPS_RELAY_MASK       16'h1fce
`define OPS_RELAY_ON         16'h0010

// ------------------------------------------------------------------
// Values and timing
// ------------------------------------------------------------------
`define OPS_BLANK_OFF        16'hffff
`define OPS_BLANK_ON         16'h0000
`define OPS_WAKE_CODE        8'hff
`define OPS_SCR_MAX_BIN      15'h2327
`define OPS_CLK_PERIOD_NS    100
`define OPS_ONE_SEC_NS       1000000000
`define OPS_SEC_CYCLES       (`OPS_ONE_SEC_NS / `OPS_CLK_PERIOD_NS)

`endif

// ==== src/ops_pkg.sv ====
// Types shared by the panel system word logic
package ops_pkg;

  typedef struct packed {
    logic        wr;
    logic        bitWr;
    logic        rd;
    logic [10:0] addr;
    logic [15:0] data;
    logic [3:0]  bitIdx;
    logic        bitVal;
  } ops_hostreq_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] code;
  } ops_intr_s;

  typedef enum logic [1:0] {
    PR_IDLE,
    PR_RUN,
    PR_DRAIN
  } ops_print_e;

endpackage

// ==== src/ops_second_tick.sv ====
// One-second tick divider and free-running seconds counter
`timescale 1ns/10ps
`default_nettype none
`include "ops_params.svh"

module ops_second_tick #(
  parameter int SEC_CYCLES = `OPS_SEC_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  output logic             tick,
  output logic [15:0]      seconds
);

  logic [31:0] divCount;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divCount <= 32'h0;
      tick     <= 1'b0;
    end else if (divCount == 32'(SEC_CYCLES - 1)) begin
      divCount <= 32'h0;
      tick     <= 1'b1;
    end else begin
      divCount <= divCount + 32'h1;
      tick     <= 1'b0;
    end
  end

  // Binary count from power-up, wraps silently
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seconds <= 16'h0;
    end else if (tick) begin
      seconds <= seconds + 16'h1; // R22
    end
  end

  a_sec_count: assert property (@(posedge mclk) disable iff (rst)
    tick |=> seconds == $past(seconds) + 16'h1) else $error("seconds counter missed a tick"); // R22

endmodule
`default_nettype wire

// ==== verif/ops_host_model.sv ====
// Host-side model issuing word, bit and read accesses to the panel system words
`timescale 1ns/10ps
`default_nettype none
`include "ops_params.svh"

module ops_host_model (
  input  wire logic             mclk,
  input  wire logic             rdValid,
  input  wire logic [15:0]      rdData,
  output ops_pkg::ops_hostreq_s req
);
  import ops_pkg::*;

  initial req = '0;

  // ------------------------------------------------------------------
  // Accesses
  // ------------------------------------------------------------------
  // Released address and data lines show inverted values so a stale address never equals the one just used
  task automatic wrWord(input logic [10:0] a, input logic [15:0] d);
    logic [15:0] v;
    v = (a == `OPS_ADDR_CONTROL) ? (d & `OPS_CTL_MASK) : d;
    if (a inside {`OPS_ADDR_RSV_A, `OPS_ADDR_RSV_B, `OPS_ADDR_RSV_C, `OPS_ADDR_RSV_D, `OPS_ADDR_RSV_E}) return;
    if (a == `OPS_ADDR_INTCODE && v[7:0] < 8'h20) return;
    @(negedge mclk);
    req.wr = 1'b1;
    req.addr = a;
    req.data = v;
    @(negedge mclk);
    req.wr = 1'b0;
    req.addr = ~a;
    req.data = ~v;
  endtask

  task automatic bitWrite(input logic [10:0] a, input logic [3:0] idx, input logic val);
    @(negedge mclk);
    req.bitWr = 1'b1;
    req.addr = a;
    req.bitIdx = idx;
    req.bitVal = val;
    @(negedge mclk);
    req.bitWr = 1'b0;
    req.addr = ~a;
    req.bitVal = ~val;
  endtask

  task automatic rdWord(input logic [10:0] a, output logic [15:0] d, output logic vld);
    @(negedge mclk);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge mclk);
    req.rd = 1'b0;
    req.addr = ~a;
    d = rdData;
    vld = rdValid;
  endtask
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
// Self-checking testbench for the panel system word block
`timescale 1ns/10ps
`default_nettype none
`include "ops_params.svh"

`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin failCount++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module tb;
  import ops_pkg::*;

  logic mclk, rst, touchEvent, numberFormatSelect, entryStrobe, entryInRange, printDone, printImageEnd;
  logic [15:0] standbySeconds, relayStatus, scanDuration, scanCount, s0, s1;
  logic rdValid, displayOn, backlightOn, buzzerInternal, buzzerAux, vgaMode, printRun, printCancel;
  logic screenChange, screenForce, windowShow, windowOrderLock, tagSuspend, vld;
  logic [15:0] rdData, windowNumber, windowPosX, windowPosY;
  logic [14:0] screenNum;
  ops_hostreq_s hostReq;
  ops_intr_s intOut;
  int failCount, comparisons;

  ops_host_model i_ops_host_model (.mclk(mclk), .rdValid(rdValid), .rdData(rdData), .req(hostReq));

  ops_system_words #(.SEC_CYCLES(20)) i_ops_system_words (
    .mclk(mclk), .rst(rst), .hostReq(hostReq), .rdValid(rdValid), .rdData(rdData), .intOut(intOut),
    .touchEvent(touchEvent), .standbySeconds(standbySeconds), .numberFormatSelect(numberFormatSelect),
    .entryStrobe(entryStrobe), .entryInRange(entryInRange), .printDone(printDone),
    .printImageEnd(printImageEnd), .relayStatus(relayStatus), .scanDuration(scanDuration),
    .scanCount(scanCount), .displayOn(displayOn), .backlightOn(backlightOn),
    .buzzerInternal(buzzerInternal), .buzzerAux(buzzerAux), .vgaMode(vgaMode), .printRun(printRun),
    .printCancel(printCancel), .screenChange(screenChange), .screenNum(screenNum),
    .screenForce(screenForce), .windowShow(windowShow), .windowOrderLock(windowOrderLock),
    .windowNumber(windowNumber), .windowPosX(windowPosX), .windowPosY(windowPosY),
    .tagSuspend(tagSuspend));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  task automatic finalReport();
    $display("Checks %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    i_ops_host_model.wrWord(a, d);
  endtask

  task automatic rdChk(input string n, input logic [10:0] a, input logic [15:0] e, input logic [15:0] m);
    logic [15:0] d;
    logic v;
    i_ops_host_model.rdWord(a, d, v);
    `CHK("rdValid", 1'b1, v)
    `CHK(n, e, d & m)
  endtask

  // One-cycle pulse on {touch, entry, printDone, imageEnd}
  task automatic pulse(input logic [3:0] m);
    @(negedge mclk);
    {touchEvent, entryStrobe, printDone, printImageEnd} = m;
    @(negedge mclk);
    {touchEvent, entryStrobe, printDone, printImageEnd} = 4'h0;
  endtask

  initial begin
    #(100 * 4000);
    failCount++;
    finalReport();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    {touchEvent, entryStrobe, printDone, printImageEnd, numberFormatSelect, entryInRange} = 6'h0;
    standbySeconds = 16'h0000;
    relayStatus = 16'hffff;
    scanDuration = 16'h1234;
    scanCount = 16'h0042;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    `CHK("displayOn", 1'b1, displayOn)
    `CHK("screenNum", 15'h0001, screenNum)
    `CHK("tagSuspend", 1'b0, tagSuspend)
    rdChk("relay", `OPS_ADDR_RELAY, (16'hffff & `OPS_RELAY_MASK) | `OPS_RELAY_ON, 16'hffff);
    rdChk("scanTime", `OPS_ADDR_SCANTIME, 16'h1234, 16'hffff);
    rdChk("scanCount", `OPS_ADDR_SCANCOUNT, 16'h0042, 16'hffff);
    rdChk("reserved", 11'h7f8, 16'h0000, 16'hffff);
    i_ops_host_model.rdWord(`OPS_ADDR_SECONDS, s0, vld);
    repeat (38) @(negedge mclk);
    i_ops_host_model.rdWord(`OPS_ADDR_SECONDS, s1, vld);
    `CHK("seconds", s0 + 16'd2, s1)
    wr(`OPS_ADDR_INTCODE, 16'h0041);
    `CHK("intValid", 1'b1, intOut.valid)
    `CHK("intCode", 8'h41, intOut.code)
    `CHK("tagSuspend", 1'b1, tagSuspend)
    @(negedge mclk);
    `CHK("intOnce", 1'b0, intOut.valid)
    wr(`OPS_ADDR_INTCODE, 16'h00ff);
    `CHK("intFF", 1'b0, intOut.valid)
    wr(`OPS_ADDR_CONTROL, 16'h0143);
    `CHK("backlight", 1'b0, backlightOn)
    `CHK("displayKept", 1'b1, displayOn)
    `CHK("buzzInt", 1'b1, buzzerInternal)
    `CHK("buzzAux", 1'b1, buzzerAux)
    `CHK("vga", 1'b1, vgaMode)
    wr(`OPS_ADDR_CONTROL, 16'h0063);
    `CHK("auxOff", 1'b0, buzzerAux)
    `CHK("buzzKept", 1'b1, buzzerInternal)
    wr(`OPS_ADDR_CONTROL, 16'h0040);
    wr(`OPS_ADDR_BLANK, `OPS_BLANK_OFF);
    `CHK("blank", 1'b0, displayOn)
    i_ops_host_model.bitWrite(`OPS_ADDR_BLANK, 4'h0, 1'b0);
    `CHK("bitBlank", 1'b0, displayOn)
    pulse(4'h8);
    `CHK("touchWake", 1'b1, displayOn)
    `CHK("wakeCode", 9'h1ff, {intOut.valid, intOut.code})
    wr(`OPS_ADDR_BLANK, `OPS_BLANK_OFF);
    standbySeconds = 16'd2;
    wr(`OPS_ADDR_BLANK, `OPS_BLANK_ON);
    `CHK("unblank", 1'b1, displayOn)
    `CHK("noWakeInt", 1'b0, intOut.valid)
    repeat (70) @(negedge mclk);
    `CHK("idleBlank", 1'b0, displayOn)
    standbySeconds = 16'd0;
    pulse(4'h8);
    wr(`OPS_ADDR_SCREEN, 16'h8005);
    `CHK("scrChange", 1'b1, screenChange)
    `CHK("scrNum", 15'h0005, screenNum)
    `CHK("scrForce", 1'b1, screenForce)
    rdChk("baseScr", `OPS_ADDR_BASESCR, 16'h0005, 16'h7fff);
    wr(`OPS_ADDR_SCREEN, 16'd9000);
    i_ops_host_model.bitWrite(`OPS_ADDR_SCREEN, 4'h0, 1'b0);
    numberFormatSelect = 1'b1;
    wr(`OPS_ADDR_SCREEN, 16'h001a);
    `CHK("scrKept", 15'h0005, screenNum)
    wr(`OPS_ADDR_SCREEN, 16'h1999);
    numberFormatSelect = 1'b0;
    `CHK("scrBcd", 15'h1999, screenNum)
    wr(`OPS_ADDR_WINCTL, 16'h0003);
    `CHK("winShow", 2'b11, {windowShow, windowOrderLock})
    i_ops_host_model.bitWrite(`OPS_ADDR_WINCTL, 4'h0, 1'b0);
    `CHK("winBit", 2'b01, {windowShow, windowOrderLock})
    rdChk("winCtl", `OPS_ADDR_WINCTL, 16'h0002, 16'hffff);
    wr(`OPS_ADDR_WINNUM, 16'h0002);
    wr(`OPS_ADDR_WINX, 16'h0120);
    wr(`OPS_ADDR_WINY, 16'h0040);
    `CHK("winPos", 48'h0002_0120_0040, {windowNumber, windowPosX, windowPosY})
    wr(`OPS_ADDR_CONTROL, 16'h0044);
    @(negedge mclk);
    `CHK("printRun", 1'b1, printRun)
    rdChk("printing", `OPS_ADDR_STATUS, 16'h0004, 16'h0004);
    wr(`OPS_ADDR_CONTROL, 16'h0840);
    @(negedge mclk);
    `CHK("cancel", 1'b1, printCancel)
    pulse(4'h1);
    `CHK("drained", 2'b00, {printRun, printCancel})
    rdChk("printing", `OPS_ADDR_STATUS, 16'h0000, 16'h0004);
    wr(`OPS_ADDR_CONTROL, 16'h0844);
    @(negedge mclk);
    `CHK("blocked", 1'b0, printRun)
    wr(`OPS_ADDR_CONTROL, 16'h0040);
    wr(`OPS_ADDR_CONTROL, 16'h0044);
    @(negedge mclk);
    `CHK("restart", 1'b1, printRun)
    pulse(4'h2);
    `CHK("printDone", 1'b0, printRun)
    i_ops_host_model.rdWord(`OPS_ADDR_STATUS, s0, vld);
    pulse(4'h4);
    rdChk("entryBad", `OPS_ADDR_STATUS, {7'h0, 1'b1, 4'h0, ~s0[3], 3'h0}, 16'h0108);
    entryInRange = 1'b1;
    pulse(4'h4);
    rdChk("entryGood", `OPS_ADDR_STATUS, {12'h0, s0[3], 3'h0}, 16'h0108);
    entryInRange = 1'b0;
    pulse(4'h4);
    wr(`OPS_ADDR_SCREEN, 16'h0003);
    rdChk("entryScr", `OPS_ADDR_STATUS, 16'h0000, 16'h0100);
    finalReport();
  end
endmodule
`default_nettype wire
